// [rtl/load_disp_pkg.sv]
// Constants and carrier types for the load and displacement conditioning block.
// Assumes one system clock; all users name items through the package scope.
package load_disp_pkg;

   // Data widths
   localparam int LOAD_W = 24;
   localparam int POS_W = 32;
   localparam int LIMIT_W = 16;

   // Display limit
   localparam logic [LIMIT_W-1:0] LIMIT_MAX = 16'h7d00;
   localparam int LIMIT_PCT = 110;
   localparam int RATED_CAP_DEF = 10000;

   // Moving average: window is 2**exponent samples, exponent 0 means bypass
   localparam int AVG_EXP_W = 4;
   localparam logic [AVG_EXP_W-1:0] AVG_EXP_MAX = 4'ha;
   localparam logic [AVG_EXP_W-1:0] AVG_EXP_AUTO = 4'ha;
   localparam int AVG_DEPTH = 1024;

   // Stability judgement defaults
   localparam int STABLE_BAND_DEF = 16;
   localparam int STABLE_RUN_DEF = 64;

   // Low-pass shift, zero means off
   localparam int LPF_W = 4;

   // Reset values
   localparam logic [POS_W-1:0] NUM_RST = 32'h0000_0001;
   localparam logic [POS_W-1:0] DEN_RST = 32'h0000_0001;

   typedef enum logic {DISP_PULSE, DISP_VOLTAGE} disp_mode_t;
   typedef enum logic {PHASE_AB, PHASE_A} enc_phase_t;

   // Load channel operating settings (not calibration)
   typedef struct packed {
      logic polarity_rev;
      logic [LPF_W-1:0] lpf_shift;
      logic [AVG_EXP_W-1:0] average_window_count;
      logic auto_smooth;
      logic signed [LOAD_W-1:0] offset;
      logic [LOAD_W-1:0] zero_window;
   } load_cfg_t;

   // Displacement calibration values, written only while unlocked
   typedef struct packed {
      disp_mode_t mode;
      enc_phase_t phase;
      logic polarity_rev;
      logic signed [POS_W-1:0] enc_display;
      logic signed [POS_W-1:0] enc_count;
      logic signed [POS_W-1:0] rated_display;
      logic signed [POS_W-1:0] rated_volt;
      logic signed [POS_W-1:0] zero_position;
   } disp_cal_t;

endpackage

// [rtl/load_disp_cond.sv]
// Load and displacement conditioning: filters, zeroing, limits, encoder scaling.
// Assumes all inputs synchronous to CORE_CLK; strobes are one-cycle pulses.
// Operation
// [RULE1] Limit defaults 110 percent; flag over-range by sign
// [RULE2] Display limit accepts only 0 to 32000
// [RULE3] Moving average of configured count; zero bypasses
// [RULE4] Smoothing only on display; hold bypasses it
// [RULE5] Stable with auto smoothing uses 1024 samples
// [RULE6] Subtract offset from every load value
// [RULE7] After zero, display equals minus offset
// [RULE8] Input outside zero window rejects zero, flags
// [RULE9] Calibration lock ignores all calibration changes
// [RULE10] Reversed polarity negates sample digitally
// [RULE11] Low-pass off passes samples unfiltered
// [RULE12] Count quadrature or single phase per selection
// [RULE13] Count scale equals display amount per count
// [RULE14] Zero balance latches present displacement reading
// [RULE15] Zero reference reports configured reference position
// [RULE16] Span capture latches reading for entered amount
// [RULE17] Voltage sensor scales by rated voltage, display
// [RULE18] Operator unlocks before calibration, relocks after
// [RULE19] Over-range compares magnitude, one limit both signs
// [RULE20] Quadrature counts by phase; ignores double transitions
`timescale 1ns/1ps
module load_disp_cond #(
   parameter int RATED_CAPACITY = load_disp_pkg::RATED_CAP_DEF,
   parameter int STABLE_BAND = load_disp_pkg::STABLE_BAND_DEF,
   parameter int STABLE_RUN = load_disp_pkg::STABLE_RUN_DEF
) (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic NRST,
   // Load samples and settings
   input wire logic LOAD_VALID_IN,
   input wire logic signed [load_disp_pkg::LOAD_W-1:0] LOAD_SAMPLE,
   input wire load_disp_pkg::load_cfg_t LOAD_CFG,
   input wire logic LIMIT_WR,
   input wire logic [load_disp_pkg::LIMIT_W-1:0] LIMIT_DATA,
   input wire logic ZERO_REQ,
   // Displacement inputs and calibration
   input wire logic ENC_A,
   input wire logic ENC_B,
   input wire logic VOLT_VALID,
   input wire logic signed [load_disp_pkg::POS_W-1:0] VOLT_SAMPLE,
   input wire logic CAL_LOCK,
   input wire logic CAL_WR,
   input wire load_disp_pkg::disp_cal_t CAL_IN,
   input wire logic ZERO_BAL,
   input wire logic SPAN_CAP,
   input wire logic signed [load_disp_pkg::POS_W-1:0] SPAN_DISPLAY,
   // Load results
   output logic LOAD_VALID,
   output logic signed [load_disp_pkg::LOAD_W-1:0] LOAD_DISPLAY,
   output logic signed [load_disp_pkg::LOAD_W-1:0] LOAD_HOLD,
   output logic OVER_POS,
   output logic OVER_NEG,
   output logic STABLE,
   output logic ZERO_DONE,
   output logic ZERO_REJECT,
   output logic [load_disp_pkg::LIMIT_W-1:0] LIMIT_VALUE,
   // Displacement results
   output logic signed [load_disp_pkg::POS_W-1:0] DISP_VALUE,
   output logic signed [load_disp_pkg::POS_W-1:0] ENC_COUNT,
   output logic CAL_REJECT
);

   localparam int LW = load_disp_pkg::LOAD_W;
   localparam int PW = load_disp_pkg::POS_W;
   localparam int SW = LW + 11;
   localparam int LIM_CALC = (RATED_CAPACITY * load_disp_pkg::LIMIT_PCT) / 100;
   localparam logic [load_disp_pkg::LIMIT_W-1:0] LIMIT_RST =
      (LIM_CALC > 32000) ? load_disp_pkg::LIMIT_MAX : load_disp_pkg::LIMIT_W'(LIM_CALC);

   function automatic logic [LW-1:0] mag(input logic signed [LW-1:0] v);
      mag = v[LW-1] ? LW'(-v) : LW'(v);
   endfunction

   // Load value after zero reference and offset removal
   function automatic logic signed [LW-1:0] corr(input logic signed [LW-1:0] v,
                                                 input logic signed [LW-1:0] z,
                                                 input logic signed [LW-1:0] o);
      corr = LW'(v - z - o); // [RULE6]
   endfunction

   // Load front end: polarity then optional low-pass
   logic signed [LW-1:0] x_ff, x_val;
   logic x_v_ff;
   logic signed [LW-1:0] pol;
   logic signed [LW:0] lpf_step;

   always_comb begin
      pol = LOAD_CFG.polarity_rev ? LW'(-LOAD_SAMPLE) : LOAD_SAMPLE; // [RULE10]
      lpf_step = ((LW+1)'(pol) - (LW+1)'(x_ff)) >>> LOAD_CFG.lpf_shift;
      if (LOAD_CFG.lpf_shift == '0) begin
         x_val = pol; // [RULE11]
      end else begin
         x_val = LW'((LW+1)'(x_ff) + lpf_step);
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         x_ff <= '0;
         x_v_ff <= 1'b0;
      end else begin
         x_v_ff <= LOAD_VALID_IN;
         if (LOAD_VALID_IN) begin
            x_ff <= x_val;
         end
      end
   end

   // Digital zero
   logic signed [LW-1:0] zero_ref_ff;
   logic zero_ok;
   assign zero_ok = mag(x_ff) <= LOAD_CFG.zero_window;

   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         zero_ref_ff <= '0;
         ZERO_DONE <= 1'b0;
         ZERO_REJECT <= 1'b0;
      end else begin
         ZERO_DONE <= ZERO_REQ && zero_ok;
         ZERO_REJECT <= ZERO_REQ && !zero_ok; // [RULE8]
         if (ZERO_REQ && zero_ok) begin
            zero_ref_ff <= x_ff; // [RULE7]
         end
      end
   end

   // Moving average history; window changes restart the fill
   logic signed [LW-1:0] hist [load_disp_pkg::AVG_DEPTH];
   logic [9:0] wr_ptr_ff;
   logic [10:0] fill_ff;
   logic signed [SW-1:0] sum_ff;
   logic [load_disp_pkg::AVG_EXP_W-1:0] exp_ff, eff_exp, cfg_exp;
   logic stable_ff;
   logic [10:0] win_n;
   logic signed [LW-1:0] old_s, avg_raw;
   logic signed [SW-1:0] nxt_sum;
   logic [10:0] nxt_fill;

   always_comb begin
      cfg_exp = (LOAD_CFG.average_window_count > load_disp_pkg::AVG_EXP_MAX) ?
                load_disp_pkg::AVG_EXP_MAX : LOAD_CFG.average_window_count;
      eff_exp = (LOAD_CFG.auto_smooth && stable_ff) ? load_disp_pkg::AVG_EXP_AUTO : cfg_exp; // [RULE5]
      win_n = 11'(11'h1 << eff_exp);
      old_s = hist[10'(wr_ptr_ff - win_n[9:0])];
      if (fill_ff == win_n) begin
         nxt_sum = sum_ff + SW'(x_ff) - SW'(old_s);
         nxt_fill = fill_ff;
      end else begin
         nxt_sum = sum_ff + SW'(x_ff);
         nxt_fill = fill_ff + 11'h1;
      end
      // The newest sample belongs to its own average, so the display does not lag a sample
      if (eff_exp == '0 || eff_exp != exp_ff || nxt_fill != win_n) begin
         avg_raw = x_ff; // [RULE3]
      end else begin
         avg_raw = LW'(nxt_sum >>> eff_exp);
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (x_v_ff) begin
         hist[wr_ptr_ff] <= x_ff;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         wr_ptr_ff <= '0;
         fill_ff <= '0;
         sum_ff <= '0;
         exp_ff <= '0;
      end else begin
         exp_ff <= eff_exp;
         if (eff_exp != exp_ff) begin
            fill_ff <= '0;
            sum_ff <= '0;
         end else if (x_v_ff) begin
            wr_ptr_ff <= wr_ptr_ff + 10'h1;
            sum_ff <= nxt_sum;
            fill_ff <= nxt_fill;
         end
      end
   end

   // Stability: input near the smoothed value for a run of samples
   logic [15:0] run_ff;
   logic signed [LW:0] dev;
   assign dev = (LW+1)'(x_ff) - (LW+1)'(avg_raw);

   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         run_ff <= '0;
         stable_ff <= 1'b0;
      end else if (x_v_ff) begin
         if ((dev[LW] ? -dev : dev) > (LW+1)'(STABLE_BAND)) begin
            run_ff <= '0;
            stable_ff <= 1'b0;
         end else if (run_ff == 16'(STABLE_RUN)) begin
            stable_ff <= 1'b1;
         end else begin
            run_ff <= run_ff + 16'h1;
         end
      end
   end
   assign STABLE = stable_ff;

   // Display limit register
   logic [load_disp_pkg::LIMIT_W-1:0] limit_ff;
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         limit_ff <= LIMIT_RST; // [RULE1]
      end else if (LIMIT_WR && LIMIT_DATA <= load_disp_pkg::LIMIT_MAX) begin
         limit_ff <= LIMIT_DATA; // [RULE2]
      end
   end
   assign LIMIT_VALUE = limit_ff;

   // Load outputs: display is smoothed, hold is not
   logic signed [LW-1:0] disp_c;
   logic over_c;
   assign disp_c = corr(avg_raw, zero_ref_ff, LOAD_CFG.offset);
   assign over_c = mag(disp_c) > LW'(limit_ff); // [RULE19]

   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         LOAD_VALID <= 1'b0;
         LOAD_DISPLAY <= '0;
         LOAD_HOLD <= '0;
         OVER_POS <= 1'b0;
         OVER_NEG <= 1'b0;
      end else begin
         LOAD_VALID <= x_v_ff;
         if (x_v_ff) begin
            LOAD_DISPLAY <= disp_c;
            LOAD_HOLD <= corr(x_ff, zero_ref_ff, LOAD_CFG.offset); // [RULE4]
            OVER_POS <= over_c && !disp_c[LW-1]; // [RULE1]
            OVER_NEG <= over_c && disp_c[LW-1];
         end
      end
   end

   // Encoder decoding
   logic a_ff, b_ff;
   logic signed [1:0] step;
   logic signed [PW-1:0] count_ff;
   load_disp_pkg::disp_cal_t cal_ff;

   always_comb begin
      step = 2'sd0;
      if (cal_ff.phase == load_disp_pkg::PHASE_A) begin
         if (ENC_A && !a_ff) begin
            step = 2'sd1; // [RULE12]
         end
      end else if ((ENC_A != a_ff) != (ENC_B != b_ff)) begin
         // Forward is A leading B; a change on both lines is ambiguous
         step = ((ENC_A ^ b_ff) != 1'b0) ? 2'sd1 : -2'sd1; // [RULE20]
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         a_ff <= 1'b0;
         b_ff <= 1'b0;
         count_ff <= '0;
      end else begin
         a_ff <= ENC_A;
         b_ff <= ENC_B;
         count_ff <= count_ff + PW'(step);
      end
   end
   assign ENC_COUNT = count_ff;

   // Displacement raw reading
   logic signed [PW-1:0] volt_ff, raw, pos;
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         volt_ff <= '0;
      end else if (VOLT_VALID) begin
         volt_ff <= VOLT_SAMPLE;
      end
   end

   always_comb begin
      raw = (cal_ff.mode == load_disp_pkg::DISP_PULSE) ? count_ff : volt_ff;
      pos = cal_ff.polarity_rev ? PW'(-raw) : raw;
   end

   // Calibration state, frozen while locked
   logic signed [PW-1:0] zero_pt_ff, num_ff, den_ff;
   logic cal_try;
   assign cal_try = CAL_WR || ZERO_BAL || SPAN_CAP;

   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         cal_ff <= '0;
         zero_pt_ff <= '0;
         num_ff <= load_disp_pkg::NUM_RST;
         den_ff <= load_disp_pkg::DEN_RST;
         CAL_REJECT <= 1'b0;
      end else begin
         CAL_REJECT <= cal_try && CAL_LOCK; // [RULE9]
         if (!CAL_LOCK) begin
            if (CAL_WR) begin
               cal_ff <= CAL_IN;
               if (CAL_IN.mode == load_disp_pkg::DISP_PULSE) begin
                  num_ff <= CAL_IN.enc_display; // [RULE13]
                  den_ff <= CAL_IN.enc_count;
               end else begin
                  num_ff <= CAL_IN.rated_display; // [RULE17]
                  den_ff <= CAL_IN.rated_volt;
               end
            end else if (ZERO_BAL) begin
               zero_pt_ff <= pos; // [RULE14]
            end else if (SPAN_CAP) begin
               num_ff <= SPAN_DISPLAY; // [RULE16]
               den_ff <= PW'(pos - zero_pt_ff);
            end
         end
      end
   end

   // Scaled displacement; a zero divisor reports the reference only
   logic signed [2*PW-1:0] prod;
   logic signed [PW-1:0] scaled;
   always_comb begin
      prod = (2*PW)'(PW'(pos - zero_pt_ff)) * (2*PW)'(num_ff);
      scaled = (den_ff == '0) ? '0 : PW'(prod / (2*PW)'(den_ff));
   end

   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         DISP_VALUE <= '0;
      end else begin
         DISP_VALUE <= scaled + cal_ff.zero_position; // [RULE15]
      end
   end

   // Checks
   property p_limit_range;
      @(posedge CORE_CLK) disable iff (!NRST) limit_ff <= load_disp_pkg::LIMIT_MAX;
   endproperty
   a_limit_range: assert property (p_limit_range) else $error("limit out of range"); // [RULE2]

   property p_limit_refuse;
      @(posedge CORE_CLK) disable iff (!NRST)
         LIMIT_WR && LIMIT_DATA > load_disp_pkg::LIMIT_MAX |=> $stable(limit_ff);
   endproperty
   a_limit_refuse: assert property (p_limit_refuse) else $error("bad limit accepted"); // [RULE2]

   property p_over;
      @(posedge CORE_CLK) disable iff (!NRST)
         x_v_ff |=> (OVER_POS || OVER_NEG) == (mag(LOAD_DISPLAY) > LW'(limit_ff)) && !(OVER_POS && OVER_NEG);
   endproperty
   a_over: assert property (p_over) else $error("over-range flag wrong"); // [RULE19]

   sequence s_zero_accept;
      ZERO_REQ && zero_ok;
   endsequence
   sequence s_zeroed_sample;
      x_v_ff && x_ff == zero_ref_ff;
   endsequence
   property p_zero;
      @(posedge CORE_CLK) disable iff (!NRST)
         s_zero_accept ##[1:20] s_zeroed_sample |=>
            LOAD_HOLD == LW'(-LOAD_CFG.offset);
   endproperty
   a_zero: assert property (p_zero) else $error("zeroed hold not minus offset"); // [RULE7]

   property p_zero_reject;
      @(posedge CORE_CLK) disable iff (!NRST)
         ZERO_REQ && !zero_ok |=> ZERO_REJECT && !ZERO_DONE && $stable(zero_ref_ff);
   endproperty
   a_zero_reject: assert property (p_zero_reject) else $error("zero not rejected"); // [RULE8]

   property p_auto;
      @(posedge CORE_CLK) disable iff (!NRST)
         LOAD_CFG.auto_smooth && stable_ff |-> win_n == 11'd1024;
   endproperty
   a_auto: assert property (p_auto) else $error("auto window not 1024"); // [RULE5]

   property p_bypass;
      @(posedge CORE_CLK) disable iff (!NRST)
         x_v_ff && eff_exp == '0 |=> LOAD_DISPLAY == LOAD_HOLD;
   endproperty
   a_bypass: assert property (p_bypass) else $error("average not bypassed"); // [RULE3]

   property p_lock;
      @(posedge CORE_CLK) disable iff (!NRST)
         CAL_LOCK && cal_try |=> $stable(num_ff) && $stable(den_ff) && $stable(zero_pt_ff) && CAL_REJECT;
   endproperty
   a_lock: assert property (p_lock) else $error("calibration changed while locked"); // [RULE9]

   property p_zero_bal;
      @(posedge CORE_CLK) disable iff (!NRST)
         ZERO_BAL && !CAL_WR && !CAL_LOCK |=> zero_pt_ff == $past(pos);
   endproperty
   a_zero_bal: assert property (p_zero_bal) else $error("zero point not latched"); // [RULE14]

   property p_quad_double;
      @(posedge CORE_CLK) disable iff (!NRST)
         cal_ff.phase == load_disp_pkg::PHASE_AB && ENC_A != a_ff && ENC_B != b_ff |=> $stable(count_ff);
   endproperty
   a_quad_double: assert property (p_quad_double) else $error("double transition counted"); // [RULE20]

   property p_quad_fwd;
      @(posedge CORE_CLK) disable iff (!NRST)
         cal_ff.phase == load_disp_pkg::PHASE_AB && !a_ff && !b_ff && ENC_A && !ENC_B |=>
            count_ff == $past(count_ff) + 1;
   endproperty
   a_quad_fwd: assert property (p_quad_fwd) else $error("forward step not counted"); // [RULE12]

endmodule // load_disp_cond

// [tb/sensor_front_model.sv]
// Far-side model: converter samples, encoder phases and voltage sensor codes.
// Assumes the bench calls its tasks from one process; every drive lands on a rising edge.
`timescale 1ns/1ps
module sensor_front_model (
   // Clock
   input wire logic clk,
   // Converter side
   output logic load_valid,
   output logic signed [load_disp_pkg::LOAD_W-1:0] load_sample,
   // Displacement side
   output logic enc_a,
   output logic enc_b,
   output logic volt_valid,
   output logic signed [load_disp_pkg::POS_W-1:0] volt_sample
);
   int q_idx;
   logic [1:0] q_seq [4];

   initial begin
      q_seq = '{2'b00, 2'b10, 2'b11, 2'b01};
      q_idx = 0;
      load_valid = 1'b0;
      load_sample = '0;
      enc_a = 1'b0;
      enc_b = 1'b0;
      volt_valid = 1'b0;
      volt_sample = '0;
   end

   // Valid stays up so that calls back to back give a gapless burst
   task automatic send_load(input logic signed [load_disp_pkg::LOAD_W-1:0] v);
      @(posedge clk);
      load_valid <= 1'b1;
      load_sample <= v;
   endtask

   // Idle data is inverted so that stale samples never look valid
   task automatic idle_load();
      @(posedge clk);
      load_valid <= 1'b0;
      load_sample <= ~load_sample;
   endtask

   // A step of 2 flips both phases at once, which a decoder must ignore
   task automatic quad(input int dir, input int n);
      for (int k = 0; k < n; k++) begin
         q_idx = (q_idx + dir + 4) % 4;
         @(posedge clk);
         {enc_a, enc_b} <= q_seq[q_idx];
         @(posedge clk);
      end
   endtask

   task automatic pulse_a(input int n);
      for (int k = 0; k < n; k++) begin
         @(posedge clk);
         enc_a <= 1'b0;
         @(posedge clk);
         enc_a <= 1'b1;
         @(posedge clk);
      end
   endtask

   task automatic toggle_b(input int n);
      for (int k = 0; k < n; k++) begin
         @(posedge clk);
         enc_b <= ~enc_b;
         @(posedge clk);
      end
   endtask

   task automatic set_volt(input logic signed [load_disp_pkg::POS_W-1:0] v);
      @(posedge clk);
      volt_valid <= 1'b1;
      volt_sample <= v;
      @(posedge clk);
      volt_valid <= 1'b0;
      volt_sample <= ~v;
   endtask
endmodule // sensor_front_model

// [tb/tb.sv]
// Self-checking bench for the load and displacement conditioning block.
// Assumes the front-end model drives the sensor pins; load results are checked from a queue.
`timescale 1ns/1ps
module tb;
   typedef struct packed {
      logic ck;
      logic signed [23:0] disp;
      logic signed [23:0] hold;
      logic op;
      logic on;
   } note_t;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic load_valid_in, enc_a, enc_b, volt_valid;
   logic signed [23:0] load_sample, load_display, load_hold, zero_ref, last_x;
   logic signed [31:0] volt_sample, span_disp, disp_value, enc_count;
   load_disp_pkg::load_cfg_t cfg, nc;
   load_disp_pkg::disp_cal_t cal_in;
   logic limit_wr, zero_req, cal_lock, cal_wr, zero_bal, span_cap;
   logic [15:0] limit_data, limit_value, limit;
   logic load_valid, over_pos, over_neg, stable, zero_done, zero_reject, cal_reject;
   note_t notes[$];
   note_t got;
   int n_fail = 0;
   int comparisons = 0;
   int cycles = 0;
   int seed;
   logic d, r, c;

   always #2.5 core_clk = ~core_clk;

   sensor_front_model fe (.clk(core_clk), .load_valid(load_valid_in), .load_sample(load_sample),
      .enc_a(enc_a), .enc_b(enc_b), .volt_valid(volt_valid), .volt_sample(volt_sample));

   load_disp_cond #(.STABLE_RUN(8)) uut (.CORE_CLK(core_clk), .NRST(nrst),
      .LOAD_VALID_IN(load_valid_in), .LOAD_SAMPLE(load_sample), .LOAD_CFG(cfg),
      .LIMIT_WR(limit_wr), .LIMIT_DATA(limit_data), .ZERO_REQ(zero_req), .ENC_A(enc_a),
      .ENC_B(enc_b), .VOLT_VALID(volt_valid), .VOLT_SAMPLE(volt_sample), .CAL_LOCK(cal_lock),
      .CAL_WR(cal_wr), .CAL_IN(cal_in), .ZERO_BAL(zero_bal), .SPAN_CAP(span_cap),
      .SPAN_DISPLAY(span_disp), .LOAD_VALID(load_valid), .LOAD_DISPLAY(load_display),
      .LOAD_HOLD(load_hold), .OVER_POS(over_pos), .OVER_NEG(over_neg), .STABLE(stable),
      .ZERO_DONE(zero_done), .ZERO_REJECT(zero_reject), .LIMIT_VALUE(limit_value),
      .DISP_VALUE(disp_value), .ENC_COUNT(enc_count), .CAL_REJECT(cal_reject));

   task automatic fail(input string msg);
      n_fail++;
      $display("mismatch at %0t: %s", $time, msg);
   endtask

   task automatic chk(input logic signed [31:0] g, input logic signed [31:0] e, input string what);
      comparisons++;
      if (g !== e) fail(what);
   endtask

   task final_report;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // Mode 0 leaves the smoothed value unchecked, 1 expects it raw, 2 expects xf
   task automatic ld(input logic signed [23:0] v, input int mode, input logic signed [23:0] xf);
      note_t n;
      int dv;
      last_x = cfg.polarity_rev ? -v : v;
      n.ck = (mode != 0);
      n.hold = last_x - zero_ref - cfg.offset;
      n.disp = (mode == 2 ? xf : last_x) - zero_ref - cfg.offset;
      dv = n.disp;
      n.op = dv > int'(limit);
      n.on = -dv > int'(limit);
      notes.push_back(n);
      fe.send_load(v);
   endtask

   // Settings change only once the pipeline has drained
   task automatic set_cfg(input load_disp_pkg::load_cfg_t nv);
      wt(3);
      cfg <= nv;
      wt(1);
   endtask

   // Collects the one-cycle answers over a few edges, whichever edge they land on
   task automatic watch();
      d = 1'b0;
      r = 1'b0;
      c = 1'b0;
      for (int i = 0; i < 4; i++) begin
         #1;
         d = d | zero_done;
         r = r | zero_reject;
         c = c | cal_reject;
         @(posedge core_clk);
      end
   endtask

   task automatic zero_cmd(input logic ok);
      wt(3);
      zero_req <= 1'b1;
      wt(1);
      zero_req <= 1'b0;
      watch();
      chk(d, ok, "zero done");
      chk(r, !ok, "zero reject");
      if (ok) zero_ref = last_x;
   endtask

   task automatic lim_wr(input logic [15:0] v);
      @(posedge core_clk);
      limit_wr <= 1'b1;
      limit_data <= v;
      @(posedge core_clk);
      limit_wr <= 1'b0;
      if (v <= 16'd32000) limit = v;
      wt(2);
      chk(limit_value, limit, "limit value");
   endtask

   task automatic cal_cmd(input int kind, input logic rej);
      @(posedge core_clk);
      if (kind == 0) cal_wr <= 1'b1;
      else if (kind == 1) zero_bal <= 1'b1;
      else span_cap <= 1'b1;
      @(posedge core_clk);
      {cal_wr, zero_bal, span_cap} <= 3'b000;
      watch();
      chk(c, rej, "cal reject");
   endtask

   task automatic cal_set(input load_disp_pkg::disp_mode_t m, input load_disp_pkg::enc_phase_t p,
                          input int a, input int b, input int zp);
      @(posedge core_clk);
      cal_in <= '{mode: m, phase: p, polarity_rev: 1'b0, enc_display: a, enc_count: b,
                  rated_display: a, rated_volt: b, zero_position: zp};
      cal_cmd(0, cal_lock);
   endtask

   always @(posedge core_clk) begin
      #1;
      if (load_valid === 1'b1) begin
         if (notes.size() == 0) begin
            fail("unexpected load result");
         end else begin
            got = notes.pop_front();
            chk(load_hold, got.hold, "hold");
            if (got.ck) begin
               chk(load_display, got.disp, "display");
               chk(over_pos, got.op, "over pos");
               chk(over_neg, got.on, "over neg");
            end
         end
      end
   end

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail("timeout");
         final_report;
      end
   end

   initial begin
      seed = 32'h7c932c9f;
      cfg = '0;
      cal_in = '0;
      {limit_wr, zero_req, cal_wr, zero_bal, span_cap} = 5'h00;
      cal_lock = 1'b1;
      limit_data = 16'h0000;
      span_disp = 32'h0000_0000;
      limit = 16'd11000;
      zero_ref = 24'h000000;
      wt(10);
      nrst <= 1'b1;
      wt(2);
      chk(limit_value, limit, "limit reset");
      chk(disp_value, 0, "disp reset");
      nc = cfg;
      nc.offset = 24'sd25;
      nc.zero_window = 24'd500;
      set_cfg(nc);
      for (int i = 0; i < 20; i++) ld(24'($random(seed) % 4000), 1, 0);
      fe.idle_load();
      nc.polarity_rev = 1'b1;
      set_cfg(nc);
      for (int i = 0; i < 5; i++) ld(24'($random(seed) % 4000), 1, 0);
      fe.idle_load();
      nc.polarity_rev = 1'b0;
      set_cfg(nc);
      ld(300, 1, 0);
      fe.idle_load();
      zero_cmd(1'b1);
      ld(300, 1, 0);
      ld(900, 1, 0);
      fe.idle_load();
      zero_cmd(1'b0);
      ld(900, 1, 0);
      fe.idle_load();
      lim_wr(16'd32001);
      lim_wr(16'd32000);
      lim_wr(16'd100);
      ld(426, 1, 0);
      ld(425, 1, 0);
      ld(174, 1, 0);
      fe.idle_load();
      lim_wr(16'd32000);
      nc.average_window_count = 4'h2;
      set_cfg(nc);
      for (int i = 1; i <= 4; i++) ld(24'(10 * i), 0, 0);
      ld(50, 2, 35);
      ld(60, 2, 45);
      fe.idle_load();
      nc.average_window_count = 4'h0;
      nc.auto_smooth = 1'b1;
      set_cfg(nc);
      for (int i = 0; i < 60 && stable !== 1'b1; i++) ld(1000, 0, 0);
      chk(stable, 1, "stable");
      for (int i = 0; i < 1030; i++) ld(1000, 0, 0);
      ld(1008, 2, 1000);
      fe.idle_load();
      nc.auto_smooth = 1'b0;
      set_cfg(nc);
      ld(1012, 1, 0);
      fe.idle_load();
      @(posedge core_clk);
      cal_lock <= 1'b0;
      cal_set(load_disp_pkg::DISP_PULSE, load_disp_pkg::PHASE_AB, 5, 2, 100);
      fe.quad(1, 10);
      wt(3);
      chk(enc_count, 10, "quad count");
      cal_cmd(1, 1'b0);
      wt(3);
      chk(disp_value, 100, "zero balance");
      fe.quad(1, 6);
      wt(3);
      chk(disp_value, 115, "scaled");
      fe.quad(2, 1);
      fe.quad(-1, 2);
      wt(3);
      chk(enc_count, 14, "double flip ignored");
      span_disp <= 32'sd40;
      cal_cmd(2, 1'b0);
      wt(3);
      chk(disp_value, 140, "span point");
      fe.quad(1, 2);
      wt(3);
      chk(disp_value, 160, "span scale");
      cal_set(load_disp_pkg::DISP_PULSE, load_disp_pkg::PHASE_A, 1, 1, 0);
      cal_cmd(1, 1'b0);
      fe.pulse_a(3);
      fe.toggle_b(2);
      wt(3);
      chk(disp_value, 3, "single phase");
      @(posedge core_clk);
      cal_lock <= 1'b1;
      cal_set(load_disp_pkg::DISP_PULSE, load_disp_pkg::PHASE_AB, 9, 1, 500);
      cal_cmd(1, 1'b1);
      cal_cmd(2, 1'b1);
      wt(3);
      chk(disp_value, 3, "locked");
      @(posedge core_clk);
      cal_lock <= 1'b0;
      cal_set(load_disp_pkg::DISP_VOLTAGE, load_disp_pkg::PHASE_AB, 50, 10, 0);
      fe.set_volt(200);
      wt(2);
      cal_cmd(1, 1'b0);
      fe.set_volt(260);
      wt(3);
      chk(disp_value, 300, "voltage scale");
      cal_in.polarity_rev <= 1'b1;
      cal_cmd(0, 1'b0);
      wt(3);
      chk(disp_value, -2300, "reversed position");
      @(posedge core_clk);
      cal_lock <= 1'b1;
      wt(5);
      chk(notes.size(), 0, "missing load results");
      final_report;
   end
endmodule // tb
